/* File: include/rps_pkg.sv */
// package: constants and types of the redundant parameter store
package rps_pkg;
  localparam int ROWS = 128;
  localparam int COLS = 4;
  localparam int ROW_AW = 7;
  localparam int PAR_ROWS = 32;
  // voted parameter rows, one bit per row
  localparam int R_FAULT_LEV = 0;
  localparam int R_LOCK = 1;
  localparam int R_AMP = 2;
  localparam int AMP_W = 2;
  localparam int R_TCW = 4;
  localparam int TCW_W = 3;
  localparam int R_TC = 7;
  localparam int TC_W = 8;
  localparam int R_TC2 = 15;
  localparam int TC2_W = 8;
  localparam int R_PARITY = 23;
  // plain data rows, not voted
  localparam int R_MAKER_ID = 32;
  localparam int R_CUST_ID = 40;
  localparam int R_LUT = 48;
  localparam int R_CRC = 112;
  localparam logic [AMP_W-1:0] AMP_FACTORY = 2'h1;
  localparam logic [2:0] CELLS_SET = 3'h7;
  // serial frame: op, row, data; first bit is msb
  localparam int FRAME_BITS = 13;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam int CNT_W = 4;
  // read-back bit time on the supply current
  localparam int CLK_NS = 20;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYC = BIT_TIME_NS / CLK_NS;
  localparam int DIV_W = 8;
  // register map
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_STATE = 8'h08;
  localparam logic [7:0] A_PARAM = 8'h0c;
  localparam logic [7:0] A_ROW_SEL = 8'h10;
  localparam logic [7:0] A_ROW_DATA = 8'h14;
  localparam int EV_W = 4;
  localparam int EV_PARITY = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_WRITTEN = 2;
  localparam int EV_READ = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SYM_LOW = 2'h0, SYM_MID = 2'h1, SYM_HIGH = 2'h2
  } rps_sym_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_RECV = 2'h1, ST_EXEC = 2'h3, ST_SEND = 2'h2
  } rps_state_t;
  function automatic logic rps_maj3(input logic [2:0] c);
    return (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]);
  endfunction : rps_maj3
endpackage : rps_pkg

/* File: verilog/rps_store.sv */
// redundant parameter store with lock, serial programming and axi access
`timescale 1ns/100ps
`default_nettype none
module rps_store
  import rps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_prog_level,
  input wire logic [1:0] pin_symbol,
  output logic supply_current_mod,
  output logic prog_mode,
  output logic diag_force,
  output logic diag_high,
  output logic [AMP_W-1:0] amp_current_sel,
  output logic [TCW_W-1:0] sensitivity_temp_coeff_range_select,
  output logic [TC_W-1:0] sensitivity_temp_coeff_fine,
  output logic [TC2_W-1:0] sensitivity_temp_coeff_curvature,
  output logic irq
);
  logic [COLS-1:0] arr_q [ROWS];
  logic [PAR_ROWS-1:0] param;
  logic parity_err, lock, session;
  logic fault_q, hv_q;
  rps_state_t st_q;
  logic [FRAME_BITS-1:0] frame_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_q;
  logic [COLS-1:0] tx_q;
  logic [1:0] sym_q;
  logic lead_edge, rx_bit, arr_we, bit_tick;
  logic [1:0] f_op;
  logic [ROW_AW-1:0] f_row;
  logic [COLS-1:0] f_data;
  logic aw_have_q, w_have_q, wr_fire;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [EV_W-1:0] status_q, mask_q, ev, clr;
  logic [ROW_AW-1:0] row_sel_q;

  // only the voted rows reach the analog settings
  always_comb begin
    for (int i = 0; i < PAR_ROWS; i++) begin
      param[i] = rps_maj3(arr_q[i][2:0]);
    end
  end
  assign parity_err = ^param;
  assign lock = param[R_LOCK];
  assign session = supply_prog_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      diag_force <= 1'b0;
      diag_high <= 1'b0;
      amp_current_sel <= AMP_FACTORY;
      sensitivity_temp_coeff_range_select <= '0;
      sensitivity_temp_coeff_fine <= '0;
      sensitivity_temp_coeff_curvature <= '0;
    end else begin
      fault_q <= parity_err;
      diag_force <= parity_err;
      diag_high <= param[R_FAULT_LEV];
      amp_current_sel <= param[R_AMP +: AMP_W];
      sensitivity_temp_coeff_range_select <= param[R_TCW +: TCW_W];
      sensitivity_temp_coeff_fine <= param[R_TC +: TC_W];
      sensitivity_temp_coeff_curvature <= param[R_TC2 +: TC2_W];
    end
  end

  // writes need the raised supply and a clear lock bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_mode <= 1'b0;
      hv_q <= 1'b0;
    end else begin
      prog_mode <= session && !lock;
      hv_q <= session;
    end
  end

  // leading edge: the line leaves the mid level
  assign lead_edge = (sym_q == SYM_MID) && (pin_symbol != SYM_MID);
  assign rx_bit = (pin_symbol == SYM_HIGH);
  assign f_op = frame_q[FRAME_BITS-1 -: 2];
  assign f_row = frame_q[COLS +: ROW_AW];
  assign f_data = frame_q[COLS-1:0];
  assign arr_we = (st_q == ST_EXEC) && (f_op == OP_WRITE) && prog_mode;
  assign bit_tick = (div_q == DIV_W'(BIT_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sym_q <= SYM_MID;
    end else begin
      sym_q <= pin_symbol;
    end
  end

  // a session without write right still allows read back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      frame_q <= '0;
      cnt_q <= '0;
    end else if (!session) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_q <= ST_RECV;
          cnt_q <= '0;
        end
        ST_RECV: begin
          if (lead_edge) begin
            frame_q <= {frame_q[FRAME_BITS-2:0], rx_bit};
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == CNT_W'(FRAME_BITS - 1)) begin
              st_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          cnt_q <= '0;
          st_q <= (f_op == OP_READ) ? ST_SEND : ST_RECV;
        end
        ST_SEND: begin
          if (bit_tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == CNT_W'(COLS - 1)) begin
              st_q <= ST_RECV;
              cnt_q <= '0;
            end
          end
        end
      endcase
    end
  end

  // read back shifts one row out lsb first on the supply current
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tx_q <= '0;
      supply_current_mod <= 1'b0;
    end else if (st_q == ST_EXEC) begin
      div_q <= '0;
      tx_q <= arr_q[f_row];
    end else if (st_q == ST_SEND) begin
      div_q <= bit_tick ? '0 : div_q + 1'b1;
      supply_current_mod <= tx_q[0];
      if (bit_tick) begin
        tx_q <= tx_q >> 1;
      end
    end else begin
      supply_current_mod <= 1'b0;
    end
  end

  // erased image keeps parity even with the factory amp setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < ROWS; r++) begin
        arr_q[r] <= '0;
      end
      arr_q[R_AMP] <= {1'b0, CELLS_SET};
      arr_q[R_PARITY] <= {1'b0, CELLS_SET};
    end else if (arr_we) begin
      arr_q[f_row] <= f_data;
    end
  end

  // axi4-lite write: address and data taken in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else begin
        s_axi_awready <= !aw_have_q && !s_axi_bvalid;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else begin
        s_axi_wready <= !w_have_q && !s_axi_bvalid;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == A_STATUS || awaddr_q == A_MASK ||
                        awaddr_q == A_ROW_SEL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
      row_sel_q <= '0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == A_MASK) begin
        mask_q <= wdata_q[EV_W-1:0];
      end
      if (awaddr_q == A_ROW_SEL) begin
        row_sel_q <= wdata_q[ROW_AW-1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle survives
  always_comb begin
    ev = '0;
    ev[EV_PARITY] = parity_err && !fault_q;
    ev[EV_REFUSED] = session && !hv_q && lock;
    ev[EV_WRITTEN] = arr_we;
    ev[EV_READ] = (st_q == ST_SEND) && bit_tick &&
                  (cnt_q == CNT_W'(COLS - 1));
    clr = '0;
    if (wr_fire && wstrb_q[0] && awaddr_q == A_STATUS) begin
      clr = wdata_q[EV_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      irq <= |(status_q & mask_q);
    end
  end

  // axi4-lite read; raw rows readable whatever the lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        A_STATUS: s_axi_rdata <= 32'(status_q);
        A_MASK: s_axi_rdata <= 32'(mask_q);
        A_STATE: s_axi_rdata <= 32'({st_q, lock, fault_q, prog_mode});
        A_PARAM: s_axi_rdata <= 32'(param);
        A_ROW_SEL: s_axi_rdata <= 32'(row_sel_q);
        A_ROW_DATA: s_axi_rdata <= 32'(arr_q[row_sel_q]);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  sequence s_read_cmd;
    (st_q == ST_EXEC) && (f_op == OP_READ) && session;
  endsequence
  sequence s_sent;
    ##[1:220] (st_q != ST_SEND);
  endsequence

  a_fault_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    parity_err |=> diag_force && fault_q)
    else $error("fault not raised after parity error");
  a_diag_low: assert property (@(posedge aclk) disable iff (!aresetn)
    parity_err && !param[R_FAULT_LEV] |=> diag_force && !diag_high)
    else $error("low diagnostic level not shown");
  a_diag_high: assert property (@(posedge aclk) disable iff (!aresetn)
    parity_err && param[R_FAULT_LEV] |=> diag_force && diag_high)
    else $error("high diagnostic level not shown");
  a_lock_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    lock |=> !prog_mode)
    else $error("program mode entered while locked");
  a_lock_write: assert property (@(posedge aclk) disable iff (!aresetn)
    arr_we |-> prog_mode && !lock)
    else $error("array written without write right");
  a_mode_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    session && !lock |=> prog_mode)
    else $error("program mode not entered");
  a_bit_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    session && st_q == ST_RECV && lead_edge |=>
    frame_q[0] == $past(rx_bit))
    else $error("serial bit not captured at leading edge");
  a_read_send: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_cmd |=> (st_q == ST_SEND) ##0 s_sent)
    else $error("read back not sent in time");
  a_sticky_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    status_q[EV_PARITY] && !clr[EV_PARITY] |=> status_q[EV_PARITY])
    else $error("status bit lost without clear");
endmodule : rps_store
`default_nettype wire

/* File: verif/rps_prog_model.sv */
// external programmer model: supply level, tri-level symbols, current sense
`timescale 1ns/100ps
`default_nettype none
module rps_prog_model
  import rps_pkg::*;
(
  input wire logic aclk,
  output logic supply_prog_level,
  output logic [1:0] pin_symbol,
  input wire logic supply_current_mod
);
  initial begin
    supply_prog_level = 1'b0;
    pin_symbol = SYM_MID;
  end
  // settle time after a supply step before any symbol
  task automatic supply_set(input logic v);
    @(posedge aclk);
    supply_prog_level <= v;
    repeat (3) @(posedge aclk);
  endtask : supply_set
  // mid before each bit, so its leading edge carries the clock
  task automatic frame(input logic [FRAME_BITS-1:0] f);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      @(posedge aclk);
      pin_symbol <= SYM_MID;
      @(posedge aclk);
      pin_symbol <= f[i] ? SYM_HIGH : SYM_LOW;
    end
    @(posedge aclk);
    pin_symbol <= SYM_MID;
  endtask : frame
  task automatic write_row(input int r, input logic [3:0] d);
    frame({OP_WRITE, r[6:0], d});
    repeat (4) @(posedge aclk);
  endtask : write_row
  // sensed mid-bit, so a few cycles of skew do no harm
  task automatic read_row(input int r, output logic [3:0] c);
    frame({OP_READ, r[6:0], 4'h0});
    repeat (3 + BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      c[i] = supply_current_mod;
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask : read_row
endmodule : rps_prog_model
`default_nettype wire

/* File: verif/test_rps_store.sv */
// self-checking bench for the redundant parameter store
`timescale 1ns/100ps
`default_nettype none
module test_rps_store;
  import rps_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, sym, amp;
  logic sup, cur, pmode, dforce, dhigh, irq;
  logic [2:0] tcr;
  logic [7:0] tcf, tcc;
  logic [3:0] cells;
  int n_fail, n_compared;
  rps_store rps_store_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_prog_level(sup), .pin_symbol(sym), .supply_current_mod(cur),
    .prog_mode(pmode), .diag_force(dforce), .diag_high(dhigh),
    .amp_current_sel(amp), .sensitivity_temp_coeff_range_select(tcr),
    .sensitivity_temp_coeff_fine(tcf), .sensitivity_temp_coeff_curvature(tcc), .irq(irq));
  rps_prog_model rps_prog_model_i (.aclk(aclk), .supply_prog_level(sup),
    .pin_symbol(sym), .supply_current_mod(cur));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chkb(input logic g, input logic e, input string m);
    chk({31'h0, g}, {31'h0, e}, m);
  endtask : chkb
  task automatic tmo;
    n_fail++;
    $display("MISMATCH %0t bus wait ran out", $time);
    close_out();
  endtask : tmo
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (n > 40) tmo();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er, input string m);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (n > 40) tmo();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e, m);
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : rd
  task automatic row(input int r, input logic [3:0] e);
    wr(A_ROW_SEL, r, RESP_OKAY);
    rd(A_ROW_DATA, {28'h0, e}, RESP_OKAY, "row cells");
  endtask : row
  task automatic prow(input int r, input logic [3:0] d);
    rps_prog_model_i.write_row(r, d);
  endtask : prow
  initial begin
    repeat (100000) @(posedge aclk);
    tmo();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, amp}, {30'h0, AMP_FACTORY}, "amp field");
    rd(A_PARAM, 32'h0080_0004, RESP_OKAY, "voted reset");
    for (int r = 0; r < ROWS; r++) begin
      row(r, (r == R_AMP || r == R_PARITY) ? 4'h7 : 4'h0);
    end
    wr(8'h18, 32'h1, RESP_SLVERR);
    wr(A_STATE, 32'h1f, RESP_SLVERR);
    rd(8'h1c, 32'h0, RESP_SLVERR, "unmapped read");
    rd(A_STATE, 32'h0, RESP_OKAY, "normal state");
    $display("test reset done");
    wr(A_MASK, 32'hf, RESP_OKAY);
    rps_prog_model_i.supply_set(1'b1);
    chkb(pmode, 1'b1, "program entry");
    prow(R_FAULT_LEV, 4'h1);
    chkb(dforce, 1'b0, "one cell masked");
    rd(A_STATUS, 32'h4, RESP_OKAY, "write event");
    wr(A_STATUS, 32'hf, RESP_OKAY);
    prow(R_FAULT_LEV, 4'h3);
    chkb(dforce, 1'b1, "two cells flip");
    chkb(dhigh, 1'b1, "high level");
    chkb(irq, 1'b1, "irq on fault");
    wr(A_STATUS, 32'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chkb(irq, 1'b0, "irq cleared");
    chkb(dforce, 1'b1, "fault held");
    wr(A_MASK, 32'h0, RESP_OKAY);
    prow(R_PARITY, 4'h0);
    chkb(dforce, 1'b0, "parity fixed");
    chkb(irq, 1'b0, "irq masked");
    wr(A_MASK, 32'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chkb(irq, 1'b1, "irq unmasked");
    prow(R_FAULT_LEV, 4'h0);
    chkb(dforce, 1'b1, "fault low");
    chkb(dhigh, 1'b0, "low level");
    prow(R_TCW, 4'h7);
    prow(R_TC, 4'h7);
    prow(R_TC2, 4'h7);
    chkb(dforce, 1'b0, "parity even");
    chk({tcc, tcf, 13'h0, tcr}, 32'h0101_0001, "sensitivity_temp_coeff fields");
    prow(R_CUST_ID, 4'hf);
    rd(A_PARAM, 32'h8094, RESP_OKAY, "voted fields");
    chkb(dforce, 1'b0, "raw row no effect");
    row(R_CUST_ID, 4'hf);
    $display("test fault done");
    wr(A_STATUS, 32'hf, RESP_OKAY);
    rps_prog_model_i.read_row(R_AMP, cells);
    chk({28'h0, cells}, 32'h7, "read back");
    rd(A_STATUS, 32'h8, RESP_OKAY, "read event");
    $display("test read back done");
    prow(R_PARITY, 4'h7);
    prow(R_LOCK, 4'h7);
    chkb(pmode, 1'b0, "locked");
    chkb(dforce, 1'b0, "lock parity");
    prow(R_CUST_ID, 4'h0);
    row(R_CUST_ID, 4'hf);
    rps_prog_model_i.supply_set(1'b0);
    wr(A_STATUS, 32'hf, RESP_OKAY);
    rps_prog_model_i.supply_set(1'b1);
    chkb(pmode, 1'b0, "entry refused");
    rd(A_STATUS, 32'h2, RESP_OKAY, "refused event");
    rps_prog_model_i.read_row(R_LOCK, cells);
    chk({28'h0, cells}, 32'h7, "locked read");
    rd(A_STATE, 32'hc, RESP_OKAY, "locked state");
    $display("test lock done");
    close_out();
  end
endmodule : test_rps_store
`default_nettype wire
